// file: src/txdlo_pkg.sv
// Constants shared by the transmit digital line output block
package txdlo_pkg;
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // Control register fields
    localparam int CTRL_FULL_BAUD  = 0;
    localparam int CTRL_POLARITY   = 1;
    localparam int CTRL_DIG_LINE   = 2;
    localparam int CTRL_CODE_SEL   = 3;
    localparam int CTRL_FSYNC_EN   = 4;
    localparam int CTRL_T1_MODE    = 5;
    localparam int CTRL_CLK_SRC_LO = 6;
    localparam int CTRL_CLK_SRC_HI = 7;
    localparam int CTRL_WIDTH      = 8;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;

    // Status register fields
    localparam int STAT_NEG_OE   = 0;
    localparam int STAT_POS_OE   = 1;
    localparam int STAT_LINE2_EN = 2;
    localparam int STAT_TX_CLK   = 3;
    localparam int STAT_FSYNC    = 4;
    localparam int STAT_WIDTH    = 5;

    // Transmit clock source selection
    localparam logic [1:0] SRC_SYS_TX   = 2'h0;
    localparam logic [1:0] SRC_RECOVERD = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h2;

    // External clock inputs sampled by the system clock
    localparam int SYNC_SYS_TX = 0;
    localparam int SYNC_RX_CLK = 1;
    localparam int SYNC_REF16  = 2;
    localparam int SYNC_COUNT  = 3;

    // Rates; the internal clock is a phase accumulator toggling twice per bit
    localparam longint CLK_HZ        = 125000000;
    localparam longint E1_BIT_HZ     = 2048000;
    localparam longint T1_BIT_HZ     = 1544000;
    localparam int     NCO_WIDTH     = 32;
    localparam logic [NCO_WIDTH-1:0] NCO_INC_E1 =
        NCO_WIDTH'((2 * E1_BIT_HZ * (64'h1 << NCO_WIDTH)) / CLK_HZ);
    localparam logic [NCO_WIDTH-1:0] NCO_INC_T1 =
        NCO_WIDTH'((2 * T1_BIT_HZ * (64'h1 << NCO_WIDTH)) / CLK_HZ);

    // Frame sync: 16.384 MHz divided down to 8 kHz; pulse spans eight reference periods, 488 ns
    localparam longint REF_HZ       = 16384000;
    localparam longint FSYNC_HZ     = 8000;
    localparam int     FSYNC_WIDTH  = 11;
    localparam logic [FSYNC_WIDTH-1:0] FSYNC_LAST =
        FSYNC_WIDTH'(REF_HZ / FSYNC_HZ - 1);
    localparam logic [FSYNC_WIDTH-1:0] FSYNC_ZERO = 11'h000;
    localparam int     FSYNC_PULSE  = 8;
    localparam logic [FSYNC_WIDTH-1:0] FSYNC_FIRST =
        FSYNC_WIDTH'(REF_HZ / FSYNC_HZ - FSYNC_PULSE);
endpackage

// file: src/txdlo_sync.sv
// Two-stage synchroniser with edge detection for one external clock
module txdlo_sync
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Asynchronous input
    input  wire logic i_async,
    // Synchronised level and edges
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First stage is read only by the second stage
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise  = sync_q & ~last_q;
    assign o_fall  = ~sync_q & last_q;
endmodule

// file: src/txdlo_top.sv
// Transmit digital line output stage with APB control
module txdlo_top
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Transmit data from the framer, one bit per rail
    input  wire logic        i_tx_mark_pos,
    input  wire logic        i_tx_mark_neg,
    // External clocks
    input  wire logic        i_system_tx_clock_in,
    input  wire logic        i_rx_recovered_clock_in,
    input  wire logic        i_system_ref_clock_in,
    // Line pins
    output logic             o_tx_neg_rail_out,
    output logic             o_tx_neg_rail_oe,
    output logic             o_tx_pos_rail_out,
    output logic             o_tx_pos_rail_oe,
    output logic             o_tx_line2_analog_en,
    output logic             o_tx_clock_out
);
    logic [txdlo_pkg::CTRL_WIDTH-1:0]  ctrl_q;
    logic [txdlo_pkg::CTRL_WIDTH-1:0]  ctrl_d;
    logic [31:0]                       prdata_q;
    logic [31:0]                       prdata_d;
    logic                              slverr_q;
    logic                              slverr_d;
    logic [txdlo_pkg::NCO_WIDTH-1:0]   nco_q;
    logic [txdlo_pkg::NCO_WIDTH-1:0]   nco_d;
    logic                              nco_clk_q;
    logic                              nco_clk_d;
    logic                              txclk_q;
    logic                              txclk_d;
    logic                              neg_q;
    logic                              neg_d;
    logic                              pos_q;
    logic                              pos_d;
    logic                              neg_bit_q;
    logic                              neg_bit_d;
    logic                              pos_bit_q;
    logic                              pos_bit_d;
    logic [txdlo_pkg::FSYNC_WIDTH-1:0] fcnt_q;
    logic [txdlo_pkg::FSYNC_WIDTH-1:0] fcnt_d;
    logic                              fsync_q;
    logic                              fsync_d;
    logic                              pin_q;
    logic                              pin_d;

    logic [txdlo_pkg::SYNC_COUNT-1:0]  ext_async;
    logic [txdlo_pkg::SYNC_COUNT-1:0]  ext_level;
    logic [txdlo_pkg::SYNC_COUNT-1:0]  ext_rise;
    logic [txdlo_pkg::SYNC_COUNT-1:0]  ext_fall;
    logic [1:0]                        clk_src;
    logic                              sel_level;
    logic                              tx_rise;
    logic                              tx_fall;
    logic                              nco_wrap;
    logic                              dual_rail;
    logic                              single_rail;
    logic                              full_baud;
    logic                              polarity;
    logic                              access;

    assign ext_async[txdlo_pkg::SYNC_SYS_TX] = i_system_tx_clock_in;
    assign ext_async[txdlo_pkg::SYNC_RX_CLK] = i_rx_recovered_clock_in;
    assign ext_async[txdlo_pkg::SYNC_REF16]  = i_system_ref_clock_in;

    // Every external clock is resampled; edges are coarse by up to one 8 ns cycle
    genvar g;
    generate
        for (g = 0; g < txdlo_pkg::SYNC_COUNT; g++)
        begin : gen_sync
            txdlo_sync u_sync
            (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_async (ext_async[g]),
                .o_level (ext_level[g]),
                .o_rise  (ext_rise[g]),
                .o_fall  (ext_fall[g])
            );
        end
    endgenerate

    assign clk_src   = ctrl_q[txdlo_pkg::CTRL_CLK_SRC_HI:txdlo_pkg::CTRL_CLK_SRC_LO];
    assign full_baud = ctrl_q[txdlo_pkg::CTRL_FULL_BAUD];
    assign polarity  = ctrl_q[txdlo_pkg::CTRL_POLARITY];
    assign dual_rail   = ctrl_q[txdlo_pkg::CTRL_DIG_LINE]
                         & ctrl_q[txdlo_pkg::CTRL_CODE_SEL];
    assign single_rail = ctrl_q[txdlo_pkg::CTRL_DIG_LINE]
                         & ~ctrl_q[txdlo_pkg::CTRL_CODE_SEL];
    assign access    = i_psel & i_penable;

    // APB: zero wait states, unmapped addresses answer with an error
    always_comb
    begin
        ctrl_d   = ctrl_q;
        prdata_d = prdata_q;
        slverr_d = 1'b0;
        if (i_psel & ~i_penable)
        begin
            prdata_d = 32'h0000_0000;
            if (i_paddr == txdlo_pkg::ADDR_CTRL)
            begin
                prdata_d[txdlo_pkg::CTRL_WIDTH-1:0] = ctrl_q;
            end
            else if (i_paddr == txdlo_pkg::ADDR_STATUS)
            begin
                prdata_d[txdlo_pkg::STAT_NEG_OE]   = o_tx_neg_rail_oe;
                prdata_d[txdlo_pkg::STAT_POS_OE]   = o_tx_pos_rail_oe;
                prdata_d[txdlo_pkg::STAT_LINE2_EN] = o_tx_line2_analog_en;
                prdata_d[txdlo_pkg::STAT_TX_CLK]   = txclk_q;
                prdata_d[txdlo_pkg::STAT_FSYNC]    = fsync_q;
            end
            else
            begin
                slverr_d = 1'b1;
            end
        end
        else if (access)
        begin
            slverr_d = slverr_q;
            if (i_pwrite && i_paddr == txdlo_pkg::ADDR_CTRL)
            begin
                ctrl_d = i_pwdata[txdlo_pkg::CTRL_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q   <= txdlo_pkg::CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign o_pready  = 1'b1;
    assign o_prdata  = prdata_q;
    assign o_pslverr = access & slverr_q;

    // Internal clock: phase accumulator, so its jitter is one 8 ns cycle
    assign nco_wrap = (nco_q + (ctrl_q[txdlo_pkg::CTRL_T1_MODE] ? txdlo_pkg::NCO_INC_T1
                                                                 : txdlo_pkg::NCO_INC_E1))
                      < nco_q;

    always_comb
    begin
        nco_d     = nco_q + (ctrl_q[txdlo_pkg::CTRL_T1_MODE] ? txdlo_pkg::NCO_INC_T1
                                                             : txdlo_pkg::NCO_INC_E1);
        nco_clk_d = nco_wrap ? ~nco_clk_q : nco_clk_q;
        case (clk_src)
            txdlo_pkg::SRC_SYS_TX:   sel_level = ext_level[txdlo_pkg::SYNC_SYS_TX];
            txdlo_pkg::SRC_RECOVERD: sel_level = ext_level[txdlo_pkg::SYNC_RX_CLK];
            txdlo_pkg::SRC_INTERNAL: sel_level = nco_clk_q;
            default:                 sel_level = nco_clk_q;
        endcase
        txclk_d = sel_level;
        tx_rise = sel_level & ~txclk_q;
        tx_fall = ~sel_level & txclk_q;
    end

    // Line data: captured and launched on transmit clock rising edges
    always_comb
    begin
        neg_bit_d = neg_bit_q;
        pos_bit_d = pos_bit_q;
        neg_d     = neg_q;
        pos_d     = pos_q;
        if (tx_rise)
        begin
            neg_bit_d = i_tx_mark_neg;
            pos_bit_d = i_tx_mark_pos;
            neg_d     = i_tx_mark_neg;
            pos_d     = i_tx_mark_pos;
        end
        else if (tx_fall && !full_baud && !single_rail)
        begin
            // Half baud returns to zero at mid-bit
            neg_d = 1'b0;
            pos_d = 1'b0;
        end
    end

    // Frame sync counts reference edges; pulse covers the last eight of each frame
    always_comb
    begin
        fcnt_d  = fcnt_q;
        fsync_d = fsync_q;
        if (ext_rise[txdlo_pkg::SYNC_REF16])
        begin
            fcnt_d  = (fcnt_q == txdlo_pkg::FSYNC_LAST) ? txdlo_pkg::FSYNC_ZERO
                                                        : fcnt_q + 1'b1;
            fsync_d = (fcnt_q >= txdlo_pkg::FSYNC_FIRST);
        end
        pin_d = ctrl_q[txdlo_pkg::CTRL_FSYNC_EN] ? fsync_d : txclk_d;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            nco_q     <= '0;
            nco_clk_q <= 1'b0;
            txclk_q   <= 1'b0;
            neg_bit_q <= 1'b0;
            pos_bit_q <= 1'b0;
            neg_q     <= 1'b0;
            pos_q     <= 1'b0;
            fcnt_q    <= txdlo_pkg::FSYNC_ZERO;
            fsync_q   <= 1'b0;
            pin_q     <= 1'b0;
        end
        else
        begin
            nco_q     <= nco_d;
            nco_clk_q <= nco_clk_d;
            txclk_q   <= txclk_d;
            neg_bit_q <= neg_bit_d;
            pos_bit_q <= pos_bit_d;
            neg_q     <= neg_d;
            pos_q     <= pos_d;
            fcnt_q    <= fcnt_d;
            fsync_q   <= fsync_d;
            pin_q     <= pin_d;
        end
    end

    // Reset clears the polarity bit, so marks drive the pins low, except o_tx_pos_rail_out in single rail, where they drive it high
    assign o_tx_neg_rail_out = polarity ? neg_q : ~neg_q;
    assign o_tx_pos_rail_out = single_rail ? (polarity ? ~pos_bit_q : pos_bit_q)
                                           : (polarity ? pos_q : ~pos_q);
    assign o_tx_neg_rail_oe  = dual_rail;
    assign o_tx_pos_rail_oe  = ctrl_q[txdlo_pkg::CTRL_DIG_LINE];
    assign o_tx_line2_analog_en = ~ctrl_q[txdlo_pkg::CTRL_DIG_LINE]
                                  & ctrl_q[txdlo_pkg::CTRL_CODE_SEL];
    assign o_tx_clock_out    = pin_q;
endmodule

// file: test/txdlo_far_end.sv
// Far-end clock sources feeding the transmit line output block
module txdlo_far_end
(
    // Clocks toward the block
    output logic o_sys_tx_clk,
    output logic o_rx_clk,
    output logic o_ref_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_sys_tx_clk = 1'b0;
        o_rx_clk     = 1'b0;
        o_ref_clk    = 1'b0;
    end
    // Link clock, 80 ns, edges aligned to system clock falling edges
    always #40 o_sys_tx_clk = ~o_sys_tx_clk;
    // Recovered clock at the E1 bit rate
    always #244.141 o_rx_clk = ~o_rx_clk;
    // Plain 16.384 MHz reference in place of a crystal, used only for frame sync
    always #30.518 o_ref_clk = ~o_ref_clk;
endmodule

// file: test/txdlo_checker.sv
// Port-level assertions for the transmit line output block
module txdlo_checker
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // APB request
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    // Line pins
    input wire logic        o_tx_neg_rail_out,
    input wire logic        o_tx_neg_rail_oe,
    input wire logic        o_tx_pos_rail_oe,
    input wire logic        o_tx_line2_analog_en,
    input wire logic        o_tx_clock_out
);
    // Control shadow, so no internal probes are needed
    logic [7:0] c_q;
    logic [7:0] r_q;
    logic [9:0] q_q;
    wire        ck = o_tx_clock_out;
    wire        wr = i_psel && i_penable && i_pwrite && i_paddr == txdlo_pkg::ADDR_CTRL;
    // Settled internal-clock dual-rail state; source changes leave a ragged edge
    wire        ic = c_q[7] && !c_q[4] && c_q[2] && c_q[3] && q_q > 10'h0C8;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            c_q <= 8'h00;
            r_q <= 8'h00;
            q_q <= 10'h000;
        end
        else
        begin
            c_q <= wr ? i_pwdata[7:0] : c_q;
            q_q <= wr ? 10'h000 : q_q + {9'h000, q_q != 10'h3FF};
            r_q <= $rose(ck) ? 8'h00 : r_q + {7'h00, r_q != 8'hFF};
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_neg_oe; q_q > 10'h002 |-> o_tx_neg_rail_oe == (c_q[2] && c_q[3]); endproperty
    a_neg_oe: assert property (p_neg_oe)
        else $error("neg rail enable wrong");
    property p_pos_oe; q_q > 10'h002 |-> o_tx_pos_rail_oe == c_q[2]; endproperty
    a_pos_oe: assert property (p_pos_oe) else $error("pos rail enable wrong");
    property p_line2; q_q > 10'h002 |-> o_tx_line2_analog_en == (!c_q[2] && c_q[3]); endproperty
    a_line2: assert property (p_line2) else $error("line 2 enable wrong");
    property p_neg_edge;
        ic && c_q[0] && $changed(o_tx_neg_rail_out) |-> (r_q < 8'h04) or ##[0:3] $rose(ck);
    endproperty
    a_neg_edge: assert property (p_neg_edge)
        else $error("neg rail moved off clock rise");
    property p_neg_half; (ic && !c_q[0] && !ck)[*4] |-> o_tx_neg_rail_out == !c_q[1]; endproperty
    a_neg_half: assert property (p_neg_half)
        else $error("half baud not idle");
    property p_clk_rate;
        ic && $rose(ck) |-> r_q inside {[(c_q[5] ? 8'h4E : 8'h3B):(c_q[5] ? 8'h52 : 8'h3E)]};
    endproperty
    a_clk_rate: assert property (p_clk_rate) else $error("tx clock period wrong");
    property p_clk_high; ic && $rose(ck) |-> ck[*8] ##1 ck; endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock pin shows pulse");
    // 488 ns is 61 or 62 system cycles; the guard skips a pulse cut by the enable write
    property p_fsync;
        c_q[4] && q_q > 10'h050 && $fell(ck) |-> r_q inside {[8'h3C:8'h3D]};
    endproperty
    a_fsync: assert property (p_fsync) else $error("frame sync width wrong");
endmodule
bind txdlo_top txdlo_checker txdlo_checker_i (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_tx_neg_rail_out, .o_tx_neg_rail_oe, .o_tx_pos_rail_oe,
    .o_tx_line2_analog_en, .o_tx_clock_out);

// file: test/txdlo_tb_top.sv
// Self-checking bench for the transmit line output block
module txdlo_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        en  = 1'b0;
    logic        wr  = 1'b0;
    logic        mk  = 1'b0;
    logic [7:0]  ad  = 8'h00;
    logic [31:0] wd  = 32'h0;
    logic [31:0] prd, rd;
    logic        rdy, err, ser, neg, noe, pos, poe, l2, ck, ckp, sc, rc, fc;
    int          failures = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    // Row: control word, mark, check neg, expected neg, enables {line2, pos, neg}
    localparam logic [15:0] RW [8] = '{16'h0040, 16'h0442, 16'h0844, 16'h0C43,
                                       16'h8D63, 16'h8F73, 16'hAF23, 16'h8C43};
    localparam int          RR [3] = '{61, 10, 10};
    txdlo_top txdlo_top_i (.i_clk(clk), .i_rst(rst), .i_psel(sel), .i_penable(en), .i_pwrite(wr),
        .i_paddr(ad), .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(ser),
        .i_tx_mark_pos(mk), .i_tx_mark_neg(mk), .i_system_tx_clock_in(sc),
        .i_rx_recovered_clock_in(rc), .i_system_ref_clock_in(fc), .o_tx_neg_rail_out(neg),
        .o_tx_neg_rail_oe(noe), .o_tx_pos_rail_out(pos), .o_tx_pos_rail_oe(poe),
        .o_tx_line2_analog_en(l2), .o_tx_clock_out(ck));
    txdlo_far_end txdlo_far_end_i (.o_sys_tx_clk(sc), .o_rx_clk(rc), .o_ref_clk(fc));
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1;
        wr  <= w;
        ad  <= a;
        wd  <= d;
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        rd  = prd;
        err = ser;
        sel <= 1'b0;
        en  <= 1'b0;
    endtask
    // Counts clock-pin rises over c cycles, or stops at the first one
    task automatic rises(input int c, input bit stop);
        n = 0;
        ckp = ck;
        repeat (c)
        begin
            @(posedge clk);
            if (ck === 1'b1 && ckp === 1'b0)
                n++;
            ckp = ck;
            if (stop && n > 0)
                return;
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp("neg_oe", 32'h0, {31'h0, noe});
        cmp("line2_en", 32'h0, {31'h0, l2});
        cmp("neg_idle", 32'h1, {31'h0, neg});
        for (int i = 0; i < 8; i++)
        begin
            mk <= RW[i][6];
            apb(1'b1, txdlo_pkg::ADDR_CTRL, {24'h0, RW[i][15:8]});
            repeat (300) @(posedge clk);
            apb(1'b0, txdlo_pkg::ADDR_CTRL, 32'h0);
            cmp("ctrl", {24'h0, RW[i][15:8]}, rd);
            apb(1'b0, txdlo_pkg::ADDR_STATUS, 32'h0);
            cmp("status", {29'h0, RW[i][2:0]}, {29'h0, rd[2:0]});
            cmp("pins", {29'h0, RW[i][2:0]}, {29'h0, l2, poe, noe});
            if (RW[i][5])
                cmp("neg", {31'h0, RW[i][4]}, {31'h0, neg});
        end
        for (int s = 0; s < 3; s++)
        begin
            apb(1'b1, txdlo_pkg::ADDR_CTRL, {24'h0, 2'(s), 6'h0D});
            repeat (100) @(posedge clk);
            rises(610, 1'b0);
            cmp("rises", 32'h1, {31'h0, n >= RR[s] - 2 && n <= RR[s] + 2});
        end
        repeat (6)
        begin
            rises(200, 1'b1);
            repeat (5) @(posedge clk);
            cmp("neg_bit", {31'h0, !mk}, {31'h0, neg});
            cmp("pos_bit", {31'h0, !mk}, {31'h0, pos});
            mk <= !mk;
        end
        // Single rail sends marks active high while the polarity bit is clear
        apb(1'b1, txdlo_pkg::ADDR_CTRL, 32'h84);
        repeat (2)
        begin
            rises(200, 1'b1);
            repeat (5) @(posedge clk);
            cmp("pos_single", {31'h0, mk}, {31'h0, pos});
            mk <= !mk;
        end
        apb(1'b1, txdlo_pkg::ADDR_CTRL, 32'h9D);
        repeat (30) @(posedge clk);
        rises(16000, 1'b1);
        n = 0;
        while (ck === 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        cmp("fsync_width", 32'h1, {31'h0, n == 61 || n == 62});
        rises(2000, 1'b0);
        cmp("fsync_gap", 32'h0, n);
        // Reset in mid-run must tristate the rails and idle the pins again
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("rst_pins", 32'h3, {26'h0, ck, l2, poe, noe, pos, neg});
        rst <= 1'b0;
        apb(1'b0, txdlo_pkg::ADDR_CTRL, 32'h0);
        cmp("rst_ctrl", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        cmp("unmapped_err", 32'h1, {31'h0, err});
        cmp("unmapped_data", 32'h0, rd);
        final_report();
    end
endmodule
